// ===== hdl/hpc_convert.sv
// packed single to half narrowing unit with exception policy and apb registers
// assumes the issue pipeline shares clk_in; requests may come every cycle
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
module hpc_convert
   import hpc_pkg::*;
#(
   parameter int LANES = 4
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic req_valid_in,
   input wire logic [LANES*32-1:0] req_src_in,
   input wire logic [7:0] req_imm_in,
   output logic res_valid_out,
   output logic [LANES*16-1:0] res_data_out,
   output logic [LANES-1:0] res_write_out,
   output logic res_trap_out,
   output logic res_refused_out,
   output logic [NFLAGS-1:0] res_flags_out,
   output logic irq_out
);
   ////////////////////////////////////////////////////////////////////////
   // register state
   logic [NFLAGS-1:0] status_ff;
   logic [CTRL_W-1:0] ctrl_ff;
   logic [NFLAGS-1:0] irq_mask_ff;
   logic [31:0] extended_control_reg_zero_ff;
   logic [31:0] prdata_ff;
   logic pslverr_ff;
   logic irq_ff;
   // request stage
   logic req_valid_ff;
   logic [LANES*32-1:0] req_src_ff;
   logic [7:0] req_imm_ff;
   // result stage
   logic res_valid_ff;
   logic [LANES*16-1:0] res_data_ff;
   logic [LANES-1:0] res_write_ff;
   logic res_trap_ff;
   logic res_refused_ff;
   logic [NFLAGS-1:0] res_flags_ff;

   ////////////////////////////////////////////////////////////////////////
   // bus handshake
   logic wr_stb;
   logic rd_load;
   logic pready_w;

   hpc_apb_port u_apb (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .psel_in(psel_in),
      .penable_in(penable_in),
      .pwrite_in(pwrite_in),
      .pready_out(pready_w),
      .wr_stb_out(wr_stb),
      .rd_load_out(rd_load)
   );

   wire hit = addr_known(paddr_in);
   wire wr_status = wr_stb && (paddr_in == REG_STATUS);
   wire wr_ctrl = wr_stb && (paddr_in == REG_CTRL);
   wire wr_irq_mask = wr_stb && (paddr_in == REG_IRQ_MASK);
   wire wr_extended_control_reg_zero = wr_stb && (paddr_in == REG_EXTENDED_CONTROL_REG_ZERO);

   wire [NFLAGS-1:0] ex_mask = ctrl_ff[NFLAGS-1:0];
   wire [1:0] ctrl_rc = ctrl_ff[CTRL_RC_LO+1:CTRL_RC_LO];

   // identification word; other bits read zero
   wire [31:0] feature_word = (32'h00000001 << FEAT_VEC_BIT) |
                              (32'h00000001 << FEAT_HALF_BIT) |
                              ({31'h00000000, ctrl_ff[CTRL_OSSAVE]} << FEAT_OSSAVE_BIT);

   wire [31:0] rd_mux = (paddr_in == REG_STATUS) ? {26'h0000000, status_ff} :
                        (paddr_in == REG_CTRL) ? {20'h00000, ctrl_ff} :
                        (paddr_in == REG_IRQ_MASK) ? {26'h0000000, irq_mask_ff} :
                        (paddr_in == REG_FEATURE) ? feature_word :
                        (paddr_in == REG_EXTENDED_CONTROL_REG_ZERO) ? extended_control_reg_zero_ff : 32'h00000000;

   // unmapped accesses give an error; unmapped reads return zero data and unmapped writes are dropped
   wire nxt_slverr = psel_in && penable_in && !pready_w && !hit;

   ////////////////////////////////////////////////////////////////////////
   // rounding choice and enable gate
   // imm[7:3] never looked at
   wire [1:0] rmode = req_imm_ff[IMM_SRC_BIT] ? ctrl_rc : req_imm_ff[1:0];
   // conversions are refused until software has enabled the vector state
   wire state_on = ((extended_control_reg_zero_ff & EXTENDED_CONTROL_REG_ZERO_NEED) == EXTENDED_CONTROL_REG_ZERO_NEED);
   wire go = req_valid_ff && state_on;
   wire refuse = req_valid_ff && !state_on;

   ////////////////////////////////////////////////////////////////////////
   // per lane arithmetic and exception policy
   logic [LANES*16-1:0] lane_res;
   logic [LANES-1:0] lane_wr;
   logic [LANES-1:0] lane_trap;
   logic [NFLAGS-1:0] lane_flags [LANES];

   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi++)
      begin : g_lane
         logic [15:0] half;
         logic nan;
         logic snan;
         logic den;
         logic tiny;
         logic inx;
         logic ovf;

         // ftz is deliberately not routed here, tiny results stay denormal
         hpc_lane u_lane (
            .src_in(req_src_ff[gi*32 +: 32]),
            .rmode_in(rmode),
            .half_out(half),
            .nan_out(nan),
            .snan_out(snan),
            .denorm_out(den),
            .tiny_out(tiny),
            .inexact_out(inx),
            .ovf_out(ovf)
         );

         // denormal unmasked is a pre-computation trap: nothing else reported
         wire de_trap = den && !ex_mask[FL_DENORM];
         wire ie = snan;
         wire ie_trap = ie && !ex_mask[FL_INVALID];
         wire ue_unm = tiny && !ex_mask[FL_UNF];
         wire oe_unm = ovf && !ex_mask[FL_OVF];
         // masked underflow only reports when the tiny result lost bits
         wire ue = tiny && (ue_unm || inx) && !de_trap;
         wire oe = ovf && !de_trap;
         // unmasked overflow only signals; no precision report with it
         wire pe = inx && !oe_unm && !de_trap;
         wire pe_trap = pe && !ex_mask[FL_PREC];
         wire hard = de_trap || ie_trap || ue_unm || oe_unm;

         // masked overflow gives signed infinity
         assign lane_res[gi*16 +: 16] = ovf ? {half[15], HP_EXP_ALL, 10'h000} : half;
         // an unmasked precision trap alone still delivers the rounded value
         assign lane_wr[gi] = !hard;
         assign lane_trap[gi] = hard || pe_trap;
         assign lane_flags[gi] = ({{(NFLAGS-1){1'b0}}, ie} << FL_INVALID) |
                                 ({{(NFLAGS-1){1'b0}}, den} << FL_DENORM) |
                                 ({{(NFLAGS-1){1'b0}}, oe} << FL_OVF) |
                                 ({{(NFLAGS-1){1'b0}}, ue} << FL_UNF) |
                                 ({{(NFLAGS-1){1'b0}}, pe} << FL_PREC);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // flag accumulation over lanes
   logic [NFLAGS-1:0] all_flags;

   always_comb
   begin
      all_flags = '0;
      for (int k = 0; k < LANES; k++)
      begin
         all_flags = all_flags | lane_flags[k];
      end
   end

   wire [NFLAGS-1:0] refuse_flag = {{(NFLAGS-1){1'b0}}, refuse} << FL_REFUSED;
   wire [NFLAGS-1:0] evt = (go ? all_flags : '0) | refuse_flag;
   wire [NFLAGS-1:0] w1c = wr_status ? pwdata_in[NFLAGS-1:0] : '0;
   // a new event in the clearing cycle survives the clear
   wire [NFLAGS-1:0] nxt_status = (status_ff & ~w1c) | evt;
   wire nxt_irq = |(nxt_status & irq_mask_ff);

   ////////////////////////////////////////////////////////////////////////
   // software registers
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         status_ff <= '0;
         ctrl_ff <= CTRL_RESET;
         irq_mask_ff <= '0;
         extended_control_reg_zero_ff <= '0;
         irq_ff <= 1'b0;
      end
      else
      begin
         status_ff <= nxt_status;
         irq_ff <= nxt_irq;
         if (wr_ctrl)
         begin
            ctrl_ff <= pwdata_in[CTRL_W-1:0];
         end
         if (wr_irq_mask)
         begin
            irq_mask_ff <= pwdata_in[NFLAGS-1:0];
         end
         if (wr_extended_control_reg_zero)
         begin
            extended_control_reg_zero_ff <= pwdata_in;
         end
      end
   end

   // read data and error, loaded on the same edge that raises pready
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pslverr_ff <= nxt_slverr;
         if (rd_load)
         begin
            prdata_ff <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request capture
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         req_valid_ff <= 1'b0;
         req_src_ff <= '0;
         req_imm_ff <= '0;
      end
      else
      begin
         req_valid_ff <= req_valid_in;
         if (req_valid_in)
         begin
            req_src_ff <= req_src_in;
            req_imm_ff <= req_imm_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result stage
   // refused requests return with no lane written and no arithmetic flags
   wire [LANES-1:0] nxt_wr = go ? lane_wr : '0;
   wire nxt_trap = go && (|lane_trap);
   wire [NFLAGS-1:0] nxt_flags = evt;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         res_valid_ff <= 1'b0;
         res_data_ff <= '0;
         res_write_ff <= '0;
         res_trap_ff <= 1'b0;
         res_refused_ff <= 1'b0;
         res_flags_ff <= '0;
      end
      else
      begin
         res_valid_ff <= req_valid_ff;
         res_write_ff <= nxt_wr;
         res_trap_ff <= nxt_trap;
         res_refused_ff <= refuse;
         res_flags_ff <= nxt_flags;
         if (go)
         begin
            res_data_ff <= lane_res;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata_out = prdata_ff;
   assign pready_out = pready_w;
   assign pslverr_out = pslverr_ff;
   assign res_valid_out = res_valid_ff;
   assign res_data_out = res_data_ff;
   assign res_write_out = res_write_ff;
   assign res_trap_out = res_trap_ff;
   assign res_refused_out = res_refused_ff;
   assign res_flags_out = res_flags_ff;
   assign irq_out = irq_ff;
endmodule : hpc_convert

// ===== hdl/hpc_pkg.sv
// constants and helpers shared by the half precision narrowing datapath
// assumes a single core clock; no state lives here
package hpc_pkg;
   ////////////////////////////////////////////////////////////////////////
   // register map, byte addresses on the apb word grid
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CTRL = 8'h04;
   localparam logic [7:0] REG_IRQ_MASK = 8'h08;
   localparam logic [7:0] REG_FEATURE = 8'h0C;
   localparam logic [7:0] REG_EXTENDED_CONTROL_REG_ZERO = 8'h10;
   ////////////////////////////////////////////////////////////////////////
   // flag positions, shared by status, exception masks and irq mask
   localparam int NFLAGS = 6;
   localparam int FL_INVALID = 0;
   localparam int FL_DENORM = 1;
   localparam int FL_REFUSED = 2;
   localparam int FL_OVF = 3;
   localparam int FL_UNF = 4;
   localparam int FL_PREC = 5;
   // control register: masks [5:0], rounding field, tiny flush, os save
   localparam int CTRL_W = 12;
   localparam int CTRL_RC_LO = 8;
   localparam int CTRL_FTZ = 10;
   localparam int CTRL_OSSAVE = 11;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h03F;
   // identification word bits
   localparam int FEAT_OSSAVE_BIT = 27;
   localparam int FEAT_VEC_BIT = 28;
   localparam int FEAT_HALF_BIT = 29;
   localparam logic [31:0] EXTENDED_CONTROL_REG_ZERO_NEED = 32'h00000006;
   ////////////////////////////////////////////////////////////////////////
   // rounding
   localparam int IMM_SRC_BIT = 2;
   localparam logic [1:0] RND_NEAR = 2'h0;
   localparam logic [1:0] RND_DOWN = 2'h1;
   localparam logic [1:0] RND_UP = 2'h2;
   // formats
   localparam logic [7:0] SP_EXP_ALL = 8'hFF;
   localparam logic [4:0] HP_EXP_ALL = 5'h1F;
   localparam logic signed [9:0] SP_BIAS = 10'sh07F;
   localparam logic signed [9:0] SP_EMIN_DEN = -10'sh07E;
   localparam logic signed [9:0] HP_BIAS = 10'sh00F;
   localparam logic signed [9:0] HP_EMIN = -10'sh00E;
   localparam logic [9:0] HP_EXP_OVF = 10'h01F;
   localparam logic [9:0] HP_QUIET = 10'h200;
   localparam logic [4:0] SHIFT_NORM = 5'h0D;
   localparam logic [4:0] SHIFT_CAP = 5'h19;
   localparam logic signed [9:0] SHIFT_SPAN = 10'sh00C;

   function automatic logic addr_known(input logic [ADDR_W-1:0] a);
      return (a == REG_STATUS) || (a == REG_CTRL) || (a == REG_IRQ_MASK) ||
             (a == REG_FEATURE) || (a == REG_EXTENDED_CONTROL_REG_ZERO);
   endfunction : addr_known
endpackage : hpc_pkg

// ===== hdl/hpc_lane.sv
// one element narrowing: single precision in, rounded half precision out
// purely combinational; the caller applies masks and registers results
`timescale 1ns/100ps
module hpc_lane
   import hpc_pkg::*;
(
   input wire logic [31:0] src_in,
   input wire logic [1:0] rmode_in,
   output logic [15:0] half_out,
   output logic nan_out,
   output logic snan_out,
   output logic denorm_out,
   output logic tiny_out,
   output logic inexact_out,
   output logic ovf_out
);
   wire sgn = src_in[31];
   wire [7:0] exp_s = src_in[30:23];
   wire [22:0] frac = src_in[22:0];
   wire exp_zero = (exp_s == 8'h00);
   wire exp_all = (exp_s == SP_EXP_ALL);
   wire is_zero = exp_zero && (frac == 23'h000000);
   wire [23:0] sig = {~exp_zero, frac};
   wire signed [9:0] unb = exp_zero ? SP_EMIN_DEN : $signed({2'h0, exp_s}) - SP_BIAS;
   // below 2^-14, denormal sources always land here
   wire tiny = !is_zero && !exp_all && (unb < HP_EMIN);
   wire signed [9:0] deficit = HP_EMIN - unb;
   // beyond the cap every bit is sticky, so a wider shifter buys nothing
   wire [4:0] shift = !tiny ? SHIFT_NORM :
                      (deficit > SHIFT_SPAN) ? SHIFT_CAP : 5'(deficit) + SHIFT_NORM;
   wire [47:0] wide = {sig, 24'h000000} >> shift;
   wire [10:0] kept = wide[34:24];
   wire rbit = wide[23];
   // at the cap the lowest significand bit falls off the shifter, keep it sticky
   wire sticky = (|wide[22:0]) || ((shift == SHIFT_CAP) && sig[0]);
   wire inc = (rmode_in == RND_NEAR) ? rbit && (sticky || kept[0]) :
              (rmode_in == RND_DOWN) ? (rbit || sticky) && sgn :
              (rmode_in == RND_UP) ? (rbit || sticky) && !sgn : 1'b0;
   wire [11:0] rnd = {1'b0, kept} + {11'h000, inc};
   wire [9:0] hexp = 10'(unb + HP_BIAS);
   // a carry out of the mantissa leaves rnd[9:0] zero, so it serves both paths
   wire [9:0] exp_n = tiny ? {9'h000, rnd[10]} : hexp + {9'h000, rnd[11]};
   wire nan = exp_all && (frac != 23'h000000);
   wire snan = nan && !frac[22];

   assign nan_out = nan;
   assign snan_out = snan;
   assign denorm_out = exp_zero && (frac != 23'h000000);
   assign tiny_out = tiny;
   wire ovf = !exp_all && !tiny && !is_zero && (exp_n >= HP_EXP_OVF);
   // an overflowed value has no exact half form either
   assign inexact_out = !exp_all && (rbit || sticky || ovf);
   assign ovf_out = ovf;
   // nan keeps sign, takes all-ones exponent, drops 13 low bits
   assign half_out = nan ? {sgn, HP_EXP_ALL, frac[22:13] | (snan ? HP_QUIET : 10'h000)} :
                     exp_all ? {sgn, HP_EXP_ALL, 10'h000} :
                     is_zero ? {sgn, 15'h0000} :
                     {sgn, exp_n[4:0], rnd[9:0]};
endmodule : hpc_lane

// ===== hdl/hpc_apb_port.sv
// apb slave handshake: one wait state, then pready for one cycle
// assumes the master holds its request until it sees pready
`timescale 1ns/100ps
module hpc_apb_port
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   output logic pready_out,
   output logic wr_stb_out,
   output logic rd_load_out
);
   logic pready_ff;
   wire access = psel_in && penable_in;
   wire nxt_pready = access && !pready_ff;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pready_ff <= 1'b0;
      end
      else
      begin
         pready_ff <= nxt_pready;
      end
   end

   assign pready_out = pready_ff;
   // write lands on the edge that samples pready high
   assign wr_stb_out = access && pready_ff && pwrite_in;
   // read data is loaded so it stands while pready is high
   assign rd_load_out = access && !pready_ff && !pwrite_in;
endmodule : hpc_apb_port

// ===== bench/hpc_issue_model.sv
// issue pipeline stand-in that drives conversion requests into the unit
// assumes issue() is entered just after a rising edge of clk_in
`timescale 1ns/100ps
module hpc_issue_model
(
   input wire logic clk_in,
   output logic req_valid_out,
   output logic [127:0] req_src_out,
   output logic [7:0] req_imm_out
);
   initial
   begin
      req_valid_out = 1'b0;
      req_src_out = 128'h0;
      req_imm_out = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////
   // hold keeps valid up so the next call lands on the very next edge
   task automatic issue(input logic [127:0] s, input logic [7:0] i, input logic hold);
      req_valid_out <= 1'b1;
      req_src_out <= s;
      req_imm_out <= i;
      @(posedge clk_in);
      if (!hold)
      begin
         req_valid_out <= 1'b0;
         // stale operands toggle so they never pass for live ones
         req_src_out <= ~s;
         req_imm_out <= ~i;
      end
   endtask : issue
endmodule : hpc_issue_model

// ===== bench/hpc_convert_assertions.sv
// port-level checks of the narrowing unit, bound into hpc_convert
// assumes one clock domain and the apb master of the bench
`timescale 1ns/100ps
module hpc_convert_assertions
   import hpc_pkg::*;
#(
   parameter int LANES = 4
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic req_valid_in,
   input wire logic res_valid_out,
   input wire logic [LANES*16-1:0] res_data_out,
   input wire logic [LANES-1:0] res_write_out,
   input wire logic res_trap_out,
   input wire logic res_refused_out,
   input wire logic [NFLAGS-1:0] res_flags_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_setup;
      psel_in && !penable_in;
   endsequence
   sequence s_one_wait;
      !pready_out ##1 pready_out;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   AST_APB_ONE_WAIT: assert property (s_setup |=> s_one_wait)
      else $error("apb answer not after exactly one wait");
   AST_PREADY_PULSE: assert property (pready_out |=> !pready_out)
      else $error("pready longer than one cycle");
   AST_DECODE_ERR: assert property (pready_out |->
      pslverr_out == (paddr_in[1:0] != 2'h0 || paddr_in > 8'h10))
      else $error("slave error does not match address decode");
   AST_RES_LATENCY: assert property (req_valid_in |-> ##2 res_valid_out)
      else $error("result not two cycles after request");
   AST_RES_CAUSE: assert property (res_valid_out |-> $past(req_valid_in, 2))
      else $error("result without request");
   AST_IDLE_QUIET: assert property (!res_valid_out |->
      !res_trap_out && !res_refused_out && res_flags_out == 6'h00)
      else $error("result flags outside result cycle");
   AST_NOWRITE_TRAPS: assert property (res_valid_out && !res_refused_out &&
      res_write_out != '1 |-> res_trap_out)
      else $error("lane suppressed without trap");
   AST_REFUSED: assert property (res_refused_out |->
      res_valid_out && res_write_out == '0 && res_flags_out == 6'h04)
      else $error("refused request wrote or flagged wrongly");
   AST_TRAP_FLAGGED: assert property (res_trap_out |-> res_flags_out != 6'h00)
      else $error("trap without flag");
   for (genvar i = 0; i < LANES; i++)
   begin : g_lane
      AST_NAN_QUIET: assert property (res_valid_out && res_write_out[i] &&
         res_data_out[16*i+10 +: 5] == 5'h1F && res_data_out[16*i +: 10] != 10'h000
         |-> res_data_out[16*i+9])
         else $error("nan lane not quiet");
   end
endmodule : hpc_convert_assertions

bind hpc_convert hpc_convert_assertions #(.LANES(LANES)) u_chk (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
   .paddr_in(paddr_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .req_valid_in(req_valid_in), .res_valid_out(res_valid_out), .res_data_out(res_data_out),
   .res_write_out(res_write_out), .res_trap_out(res_trap_out),
   .res_refused_out(res_refused_out), .res_flags_out(res_flags_out));

// ===== bench/hpc_convert_tb_top.sv
// self-checking bench for the packed single to half narrowing unit
// assumes hpc_pkg, the design and the issue model are compiled first
`timescale 1ns/100ps
module hpc_convert_tb_top;
   import hpc_pkg::*;
   typedef struct packed {
      logic [11:0] ctrl;
      logic [31:0] src;
      logic [7:0] imm;
      logic [15:0] half;
      logic [5:0] flags;
      logic wr;
      logic trap;
   } hpc_row_t;
   // suppressed lanes still carry the computed half; only refusal holds the data
   localparam hpc_row_t ROWS [0:17] = '{
      '{12'h03F, 32'h3F800000, 8'h00, 16'h3C00, 6'h00, 1'b1, 1'b0},
      '{12'h03F, 32'h477FE000, 8'h00, 16'h7BFF, 6'h00, 1'b1, 1'b0},
      '{12'h03F, 32'h47800000, 8'h00, 16'h7C00, 6'h28, 1'b1, 1'b0},
      '{12'h03F, 32'hC7800000, 8'h03, 16'hFC00, 6'h28, 1'b1, 1'b0},
      '{12'h43F, 32'h38000000, 8'h00, 16'h0200, 6'h00, 1'b1, 1'b0},
      '{12'h03F, 32'h3F800001, 8'h00, 16'h3C00, 6'h20, 1'b1, 1'b0},
      '{12'h03F, 32'h3F800001, 8'hFA, 16'h3C01, 6'h20, 1'b1, 1'b0},
      '{12'h03F, 32'hBF800001, 8'h01, 16'hBC01, 6'h20, 1'b1, 1'b0},
      '{12'h03F, 32'hBF800001, 8'h03, 16'hBC00, 6'h20, 1'b1, 1'b0},
      '{12'h23F, 32'h3F800001, 8'h04, 16'h3C01, 6'h20, 1'b1, 1'b0},
      '{12'h01F, 32'h3F800001, 8'h00, 16'h3C00, 6'h20, 1'b1, 1'b1},
      '{12'h03F, 32'hFF800001, 8'h00, 16'hFE00, 6'h01, 1'b1, 1'b0},
      '{12'h03F, 32'h7FC02000, 8'h00, 16'h7E01, 6'h00, 1'b1, 1'b0},
      '{12'h03F, 32'h00000001, 8'h00, 16'h0000, 6'h32, 1'b1, 1'b0},
      '{12'h02F, 32'h38000000, 8'h00, 16'h0200, 6'h10, 1'b0, 1'b1},
      '{12'h02F, 32'h00000001, 8'h00, 16'h0000, 6'h32, 1'b0, 1'b1},
      '{12'h037, 32'h47800000, 8'h00, 16'h7C00, 6'h08, 1'b0, 1'b1},
      '{12'h03D, 32'h00000001, 8'h00, 16'h0000, 6'h02, 1'b0, 1'b1}
   };
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   logic req_valid_in;
   logic [127:0] req_src_in;
   logic [7:0] req_imm_in;
   logic res_valid_out;
   logic [63:0] res_data_out;
   logic [3:0] res_write_out;
   logic res_trap_out;
   logic res_refused_out;
   logic [5:0] res_flags_out;
   logic irq_out;
   logic [31:0] rd;
   logic err;
   int error_cnt = 0;
   int tests_run = 0;
   always #12.5 clk_in = ~clk_in;
   hpc_convert #(.LANES(4)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .req_valid_in(req_valid_in), .req_src_in(req_src_in),
      .req_imm_in(req_imm_in), .res_valid_out(res_valid_out), .res_data_out(res_data_out),
      .res_write_out(res_write_out), .res_trap_out(res_trap_out),
      .res_refused_out(res_refused_out), .res_flags_out(res_flags_out), .irq_out(irq_out));
   hpc_issue_model u_issue (.clk_in(clk_in), .req_valid_out(req_valid_in),
      .req_src_out(req_src_in), .req_imm_out(req_imm_in));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   // entered just after a rising edge; waits for pready with no assumed latency
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do @(posedge clk_in); while (pready_out !== 1'b1 && ++n < 50);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      // one idle cycle so the next call never re-drives psel in this step
      @(posedge clk_in);
   endtask : apb
   task automatic wait_res();
      int n;
      n = 0;
      do @(posedge clk_in); while (res_valid_out !== 1'b1 && ++n < 20);
   endtask : wait_res
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (5000) @(posedge clk_in);
      error_cnt++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      check("res_valid", 80'(res_valid_out), 80'h0);
      apb(1'b0, REG_CTRL, 32'h0);
      check("ctrl", 80'(rd), 80'h03F);
      apb(1'b1, REG_CTRL, 32'h0000083F);
      apb(1'b1, REG_EXTENDED_CONTROL_REG_ZERO, 32'h00000006);
      apb(1'b1, REG_FEATURE, 32'h0);
      apb(1'b0, REG_FEATURE, 32'h0);
      check("feature", 80'(rd & 32'h38000000), 80'h38000000);
      apb(1'b0, REG_EXTENDED_CONTROL_REG_ZERO, 32'h0);
      check("extended_control_reg_zero", 80'(rd & 32'h6), 80'h6);
      apb(1'b0, 8'h14, 32'h0);
      check("unmapped", 80'({err, rd}), 80'h100000000);
      $display("test registers done");
      foreach (ROWS[k])
      begin
         apb(1'b1, REG_CTRL, {20'h0, ROWS[k].ctrl});
         u_issue.issue({4{ROWS[k].src}}, ROWS[k].imm, 1'b0);
         wait_res();
         check("row", 80'({res_data_out, res_write_out, res_flags_out, res_trap_out}),
            80'({{4{ROWS[k].half}}, {4{ROWS[k].wr}}, ROWS[k].flags, ROWS[k].trap}));
      end
      $display("test rows done");
      apb(1'b1, REG_CTRL, 32'h0000083F);
      apb(1'b1, REG_STATUS, 32'h0000003F);
      // back to back with lanes that differ in kind
      u_issue.issue({32'h7F800001, 32'h47800000, 32'h3F800001, 32'h3F800000}, 8'h00, 1'b1);
      u_issue.issue({4{32'h3F800000}}, 8'h00, 1'b0);
      wait_res();
      check("packed", 80'({res_data_out, res_write_out, res_flags_out}),
         80'({64'h7E007C003C003C00, 4'hF, 6'h29}));
      @(posedge clk_in);
      check("second", 80'({res_valid_out, res_data_out, res_flags_out}),
         80'({1'b1, 64'h3C003C003C003C00, 6'h00}));
      apb(1'b1, REG_STATUS, 32'h00000001);
      apb(1'b0, REG_STATUS, 32'h0);
      check("status", 80'(rd), 80'h28);
      apb(1'b1, REG_IRQ_MASK, 32'h00000008);
      repeat (2) @(posedge clk_in);
      check("irq_on", 80'(irq_out), 80'h1);
      apb(1'b1, REG_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk_in);
      check("irq_masked", 80'(irq_out), 80'h0);
      apb(1'b1, REG_IRQ_MASK, 32'h00000008);
      apb(1'b1, REG_STATUS, 32'h00000008);
      repeat (2) @(posedge clk_in);
      check("irq_cleared", 80'(irq_out), 80'h0);
      $display("test status done");
      apb(1'b1, REG_EXTENDED_CONTROL_REG_ZERO, 32'h00000002);
      u_issue.issue({4{32'h3F800000}}, 8'h00, 1'b0);
      wait_res();
      check("refused", 80'({res_refused_out, res_write_out, res_flags_out}),
         80'({1'b1, 4'h0, 6'h04}));
      apb(1'b1, REG_EXTENDED_CONTROL_REG_ZERO, 32'h00000006);
      $display("test refusal done");
      close_out();
   end
endmodule : hpc_convert_tb_top
